// [xcsb_top.sv]
// Chip select base address bank for external bus selects one to three
//
// Notes on behaviour
// - Select one low byte holds address bits 7:2
// - Select one protect bit locks its register pair
// - Protect clears only on power or bus reset
// - Select one disable bit: one turns select off
// - Select two high byte holds address 15:8
// - Mode one: select two low bits 7:2
// - Mode two: bits 7:4 only, 3:2 reserved
// - Select two protect bit locks its pair
// - Select two disable bit: one turns select off
// - Select three high byte holds address 15:8
// - Select three protect bit locks its pair
// - Out of range base is ignored
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "xcsb_map.svh"
module xcsb_top #(
  parameter int IO_ADDR_W = 16,
  parameter int NUM_SEL = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic softRst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic busModeTwo,
  input wire logic ioValid,
  input wire logic [15:0] ioAddr,
  output logic extSelectOne,
  output logic extSelectTwoLowN,
  output logic extSelectThreeLowN
);
  // -----------------------------------------------------------------
  // Elaboration checks
  // -----------------------------------------------------------------
  // The compare is built for a sixteen bit cycle and three selects
  if (IO_ADDR_W != 16 || NUM_SEL != 3) begin : gBadParam
    $error("xcsb_top supports only 16 address bits and 3 selects");
  end

  // -----------------------------------------------------------------
  // Per select constants
  // -----------------------------------------------------------------
  // Index 0 is select one, index 2 is select three
  localparam logic [2:0][7:0] HI_OFS = {
    `XCSB_CS3_HI_OFS,
    `XCSB_CS2_HI_OFS,
    `XCSB_CS1_HI_OFS
  };
  localparam logic [2:0][7:0] LO_OFS = {
    `XCSB_CS3_LO_OFS,
    `XCSB_CS2_LO_OFS,
    `XCSB_CS1_LO_OFS
  };
  // Select one keeps the full low field in both modes
  localparam logic [2:0] MODE_AW = 3'h6;
  // Select one drives high when active, the others low
  localparam logic [2:0] ACT_LOW = 3'h6;

  // -----------------------------------------------------------------
  // Shared signals
  // -----------------------------------------------------------------
  xcsb_pkg::xcsb_mode_t busMode; // Decoded layout mode
  logic [2:0][7:0] hiRdArr; // High byte read views
  logic [2:0][7:0] loRdArr; // Low byte read views
  logic [2:0] wpArr; // Protect bits
  logic [2:0] disArr; // Disable bits
  logic [2:0] selPin; // Chip select pins at pin level
  logic [7:0] rdData_q, rdData_d; // Read data register

  // Mode setting lives outside this bank and arrives on our clock
  assign busMode = busModeTwo ? xcsb_pkg::XCSB_MODE_TWO
                              : xcsb_pkg::XCSB_MODE_ONE;

  // -----------------------------------------------------------------
  // One register pair and one decoder per select
  // -----------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : gSel
    xcsb_sel_if sel();
    // Register pair with its own sticky protect
    xcsb_csreg #(
      .HI_OFS(HI_OFS[i]),
      .LO_OFS(LO_OFS[i]),
      .MODE_AWARE(MODE_AW[i])
    ) uReg (
      .clk(clk),
      .rstn(rstn),
      .softRst(softRst),
      .wrStb(regWr),
      .addr(regAddr),
      .wrData(regWrData),
      .busMode(busMode),
      .sel(sel.regs)
    );
    // Decoder fed from the pair
    xcsb_match #(
      .ACT_LOW(ACT_LOW[i])
    ) uMatch (
      .clk(clk),
      .rstn(rstn),
      .ioValid(ioValid),
      .ioAddr(ioAddr),
      .sel(sel.dec),
      .selOut(selPin[i])
    );
    assign hiRdArr[i] = sel.hiRd;
    assign loRdArr[i] = sel.loRd;
    assign wpArr[i] = sel.wp;
    assign disArr[i] = sel.selOff;
  end

  // -----------------------------------------------------------------
  // Read path
  // -----------------------------------------------------------------
  // Unmapped offsets answer zero; data stand one cycle only
  always_comb begin
    rdData_d = `XCSB_RST_VAL;
    if (regRd) begin
      for (int i = 0; i < 3; i++) begin
        if (regAddr == HI_OFS[i]) begin
          rdData_d = hiRdArr[i];
        end
        if (regAddr == LO_OFS[i]) begin
          rdData_d = loRdArr[i];
        end
      end
    end
  end

  // Read data register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= `XCSB_RST_VAL;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign regRdData = rdData_q;
  assign extSelectOne = selPin[0];
  assign extSelectTwoLowN = selPin[1];
  assign extSelectThreeLowN = selPin[2];

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Helper terms for writes that are allowed to land
  logic wrLo1, wrHi2, wrLo2;
  assign wrLo1 = regWr && regAddr == LO_OFS[0] && !wpArr[0] && !softRst;
  assign wrHi2 = regWr && regAddr == HI_OFS[1] && !wpArr[1] && !softRst;
  assign wrLo2 = regWr && regAddr == LO_OFS[1] && !wpArr[1] && !softRst;

  // Select one low field follows the written bits 7:2
  lo1_field_a: assert property (
    wrLo1 |=> loRdArr[0][7:2] == $past(regWrData[7:2])
  ) else $error("select one low field not stored");

  // Protected pair of select one keeps its high byte
  hi1_lock_a: assert property (
    wpArr[0] && regWr && regAddr == HI_OFS[0] && !softRst
    |=> $stable(hiRdArr[0])
  ) else $error("select one high byte written while protected");

  // Unprotected select one high byte takes the whole written byte
  hi1_store_a: assert property (
    regWr && regAddr == HI_OFS[0] && !wpArr[0] && !softRst
    |=> hiRdArr[0] == $past(regWrData)
  ) else $error("select one high byte not stored");

  // Protected select one low byte ignores writes; its layout has no mode
  lo1_lock_a: assert property (
    wpArr[0] && regWr && regAddr == LO_OFS[0] && !softRst
    |=> $stable(loRdArr[0])
  ) else $error("select one low byte written while protected");

  // Protect bits never fall while power and bus reset are absent
  wp_sticky_a: assert property (
    wpArr != 3'h0 |=> (wpArr & $past(wpArr)) == $past(wpArr)
  ) else $error("protect bit cleared without reset");

  // Soft reset leaves protect alone and reads it back as one
  wp_soft_a: assert property (
    softRst && wpArr[2] |=> wpArr[2] && loRdArr[2][1]
  ) else $error("soft reset touched protect");

  // Soft reset clears every high address byte and disable bit
  soft_clear_a: assert property (
    softRst |=> hiRdArr == 24'h000000 && disArr == 3'h0
  ) else $error("soft reset left address or disable bits");

  // Select one disabled for two cycles stays off in both answers
  dis1_off_a: assert property (
    disArr[0] [*2] |-> !extSelectOne [*2]
  ) else $error("disabled select one asserted");

  // Select two high byte stores the whole written byte
  hi2_store_a: assert property (
    wrHi2 |=> hiRdArr[1] == $past(regWrData)
  ) else $error("select two high byte not stored");

  // Mode one keeps select two bits 3:2
  lo2_m1_a: assert property (
    wrLo2 && !busModeTwo ##1 !busModeTwo
    |-> loRdArr[1][7:2] == $past(regWrData[7:2])
  ) else $error("select two mode one field wrong");

  // Mode two reads the reserved bits of select two as zero
  lo2_m2_a: assert property (
    busModeTwo |-> loRdArr[1][3:2] == 2'h0
  ) else $error("select two reserved bits nonzero");

  // Protected select two low byte ignores writes; a mode change may re-mask it
  lo2_lock_a: assert property (
    wpArr[1] && regWr && regAddr == LO_OFS[1] && !softRst ##1 $stable(busModeTwo)
    |-> $stable(loRdArr[1])
  ) else $error("select two low byte written while protected");

  // Protected select two high byte ignores writes
  hi2_lock_a: assert property (
    wpArr[1] && regWr && regAddr == HI_OFS[1] && !softRst
    |=> $stable(hiRdArr[1])
  ) else $error("select two high byte written while protected");

  // A written protect bit of select two sets even beside soft reset
  wp_set_a: assert property (
    regWr && regAddr == LO_OFS[1] && regWrData[`XCSB_WP_BIT] |=> wpArr[1]
  ) else $error("select two protect bit not set");

  // Disabled select two keeps its pin high
  dis2_off_a: assert property (
    disArr[1] |=> extSelectTwoLowN
  ) else $error("disabled select two asserted");

  // Unprotected select three high byte takes the whole written byte
  hi3_store_a: assert property (
    regWr && regAddr == HI_OFS[2] && !wpArr[2] && !softRst
    |=> hiRdArr[2] == $past(regWrData)
  ) else $error("select three high byte not stored");

  // Protected select three high byte ignores writes
  hi3_lock_a: assert property (
    wpArr[2] && regWr && regAddr == HI_OFS[2] && !softRst
    |=> $stable(hiRdArr[2])
  ) else $error("select three high byte written while protected");

  // Protected select three low byte ignores writes
  lo3_lock_a: assert property (
    wpArr[2] && regWr && regAddr == LO_OFS[2] && !softRst ##1 $stable(busModeTwo)
    |-> $stable(loRdArr[2])
  ) else $error("select three low byte written while protected");

  // Disabled select three keeps its pin high
  dis3_off_a: assert property (
    disArr[2] |=> extSelectThreeLowN
  ) else $error("disabled select three asserted");

  // A base above the permitted range never drives select three
  range3_a: assert property (
    hiRdArr[2][7:4] != `XCSB_RANGE_NIB |=> extSelectThreeLowN
  ) else $error("out of range base selected");

  // A base above the permitted range never drives select one
  range1_a: assert property (
    hiRdArr[0][7:4] != `XCSB_RANGE_NIB |=> !extSelectOne
  ) else $error("out of range base selected on select one");

  // Exact match on an enabled select three asserts next cycle
  match3_a: assert property (
    ioValid && !disArr[2] && hiRdArr[2][7:4] == `XCSB_RANGE_NIB &&
    ioAddr[15:8] == hiRdArr[2] &&
    ioAddr[7:4] == loRdArr[2][7:4] &&
    (busModeTwo || ioAddr[3:2] == loRdArr[2][3:2])
    |=> !extSelectThreeLowN
  ) else $error("matching select three not asserted");

  // Exact match on an enabled select one asserts next cycle in either mode
  match1_a: assert property (
    ioValid && !disArr[0] && hiRdArr[0][7:4] == `XCSB_RANGE_NIB &&
    ioAddr[15:8] == hiRdArr[0] && ioAddr[7:2] == loRdArr[0][7:2]
    |=> extSelectOne
  ) else $error("matching select one not asserted");

  // Without a cycle no select is active in the next cycle
  idle_a: assert property (
    !ioValid |=> !extSelectOne && extSelectTwoLowN && extSelectThreeLowN
  ) else $error("select active without cycle");

  // A read of select one low byte returns protect and disable
  rd1_view_a: assert property (
    regRd && regAddr == LO_OFS[0]
    |=> regRdData[1:0] == {$past(wpArr[0]), $past(disArr[0])}
  ) else $error("select one low byte read wrong");
endmodule
`default_nettype wire

// [xcsb_map.svh]
// Register offsets, field positions and reset values of the chip select base bank
`ifndef XCSB_MAP_SVH
`define XCSB_MAP_SVH
// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define XCSB_CS1_HI_OFS 8'h62
`define XCSB_CS1_LO_OFS 8'h63
`define XCSB_CS2_HI_OFS 8'h64
`define XCSB_CS2_LO_OFS 8'h65
`define XCSB_CS3_HI_OFS 8'h66
`define XCSB_CS3_LO_OFS 8'h67
// -----------------------------------------------------------------
// Fields and reset values
// -----------------------------------------------------------------
`define XCSB_WP_BIT 1
`define XCSB_DIS_BIT 0
`define XCSB_RST_VAL 8'h00
`define XCSB_M1_LOW_MASK 8'hfc
`define XCSB_M2_LOW_MASK 8'hf0
`define XCSB_DIS_MASK 8'h01
`define XCSB_RANGE_NIB 4'h0
`endif

// [xcsb_pkg.sv]
// Types shared by the chip select base bank modules
`default_nettype none
package xcsb_pkg;
  // Low-byte field layout chosen outside this bank
  typedef enum logic [1:0] {
    XCSB_MODE_ONE = 2'b01,
    XCSB_MODE_TWO = 2'b10
  } xcsb_mode_t;
endpackage
`default_nettype wire

// [xcsb_sel_if.sv]
// Carrier between one select's register pair and its address decoder
`timescale 1ns/10ps
`default_nettype none
interface xcsb_sel_if;
  // -----------------------------------------------------------------
  // Programmed state of one chip select
  // -----------------------------------------------------------------
  logic [15:0] base; // Base address, undefined low bits already zero
  logic [7:0] lowMask; // Low-byte bits that take part in the compare
  logic selOff; // Disable bit
  logic wp; // Sticky write protect
  logic [7:0] hiRd; // Read view of the high byte
  logic [7:0] loRd; // Read view of the low byte
  modport regs (output base, lowMask, selOff, wp, hiRd, loRd);
  modport dec (input base, lowMask, selOff);
endinterface
`default_nettype wire

// [xcsb_csreg.sv]
// High and low base register pair of one chip select with write protect
`timescale 1ns/10ps
`default_nettype none
`include "xcsb_map.svh"
module xcsb_csreg #(
  parameter logic [7:0] HI_OFS = `XCSB_CS2_HI_OFS,
  parameter logic [7:0] LO_OFS = `XCSB_CS2_LO_OFS,
  parameter bit MODE_AWARE = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic softRst,
  input wire logic wrStb,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire xcsb_pkg::xcsb_mode_t busMode,
  xcsb_sel_if.regs sel
);
  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  logic [7:0] hi_q, hi_d; // Address bits 15:8
  logic [7:0] lo_q, lo_d; // Address bits 7:2 and disable bit
  logic wp_q, wp_d; // Sticky write protect
  logic [7:0] mask; // Low-byte compare mask for the current mode

  // Mode two narrows the low field; select one ignores the mode
  assign mask = (MODE_AWARE && busMode == xcsb_pkg::XCSB_MODE_TWO) ?
                `XCSB_M2_LOW_MASK : `XCSB_M1_LOW_MASK;

  // Next values: writes gated by protect, soft reset spares protect
  always_comb begin
    hi_d = hi_q;
    lo_d = lo_q;
    wp_d = wp_q;
    if (wrStb && !wp_q) begin
      if (addr == HI_OFS) begin
        hi_d = wrData;
      end
      if (addr == LO_OFS) begin
        // Bits outside the mode's field, save the disable bit, are kept out of storage
        lo_d = wrData & (mask | `XCSB_DIS_MASK);
        wp_d = wrData[`XCSB_WP_BIT];
      end
    end
    if (softRst) begin
      // Protect is untouched so soft reset cannot unlock the pair
      hi_d = `XCSB_RST_VAL;
      lo_d = `XCSB_RST_VAL;
    end
  end

  // Only power and bus resets reach the protect bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hi_q <= `XCSB_RST_VAL;
      lo_q <= `XCSB_RST_VAL;
      wp_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      wp_q <= wp_d;
    end
  end

  // -----------------------------------------------------------------
  // Views for the decoder and the read path
  // -----------------------------------------------------------------
  assign sel.base = {hi_q, lo_q & mask};
  assign sel.lowMask = mask;
  assign sel.selOff = lo_q[`XCSB_DIS_BIT];
  assign sel.wp = wp_q;
  assign sel.hiRd = hi_q;
  assign sel.loRd = (lo_q & (mask | `XCSB_DIS_MASK)) | {6'h00, wp_q, 1'b0};
endmodule
`default_nettype wire

// [xcsb_match.sv]
// Address compare and registered chip select output for one select
`timescale 1ns/10ps
`default_nettype none
`include "xcsb_map.svh"
module xcsb_match #(
  parameter bit ACT_LOW = 1'b1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ioValid,
  input wire logic [15:0] ioAddr,
  xcsb_sel_if.dec sel,
  output logic selOut
);
  // -----------------------------------------------------------------
  // Compare
  // -----------------------------------------------------------------
  logic hit; // Cycle addresses this select
  logic sel_q, sel_d; // Output at pin level

  // A base above the permitted range never selects anything
  always_comb begin
    hit = ioValid && !sel.selOff &&
          (sel.base[15:12] == `XCSB_RANGE_NIB) &&
          ((ioAddr & {8'hff, sel.lowMask}) == sel.base);
    sel_d = hit ^ ACT_LOW;
  end

  // Registered so the pin never glitches during the compare
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= ACT_LOW;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign selOut = sel_q;
endmodule
`default_nettype wire

// [xcsb_ext_dev.sv]
// External bus component model that turns the three select pins into hit flags
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Far side model
// -----------------------------------------------------------------
module xcsb_ext_dev (
  input wire logic selOne,
  input wire logic selTwoLowN,
  input wire logic selThreeLowN,
  output logic [2:0] hit
);
  // One component per select; two and three respond to a low pin
  assign hit = {~selThreeLowN, ~selTwoLowN, selOne};
endmodule
`default_nettype wire

// [xcsb_top_tb.sv]
// Self-checking testbench for the chip select base bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checkCount++; if ((got) !== (exp)) begin errCount++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module xcsb_top_tb;
  // -----------------------------------------------------------------
  // Stimulus and observed signals
  // -----------------------------------------------------------------
  logic clk, rstn, softRst, regWr, regRd, busModeTwo, ioValid;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [15:0] ioAddr;
  logic selOne, selTwoLowN, selThreeLowN;
  logic [2:0] hit; // Decoded by the far side model
  int errCount, checkCount;

  xcsb_top i_xcsb_top (.clk(clk), .rstn(rstn), .softRst(softRst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .busModeTwo(busModeTwo), .ioValid(ioValid), .ioAddr(ioAddr), .extSelectOne(selOne),
    .extSelectTwoLowN(selTwoLowN), .extSelectThreeLowN(selThreeLowN));
  xcsb_ext_dev i_xcsb_ext_dev (.selOne(selOne), .selTwoLowN(selTwoLowN),
    .selThreeLowN(selThreeLowN), .hit(hit));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // -----------------------------------------------------------------
  // Bus and pin tasks; each starts at the next edge so no signal is set twice
  // -----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdData, exp)
  endtask

  // One sampled host cycle; selects answer one cycle later
  task automatic io(input logic [15:0] a, input logic [2:0] exp);
    @(posedge clk);
    ioValid <= 1'b1;
    ioAddr <= a;
    @(posedge clk);
    ioValid <= 1'b0;
    #1;
    `CHK(hit, exp)
  endtask

  // Power or bus reset; the only way to drop a protect bit
  task automatic doReset();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  // Reset values, unmapped place and read data lifetime
  task automatic t_reset_vals();
    for (int i = 8'h62; i <= 8'h67; i++) begin
      rd(8'(i), 8'h00);
    end
    wr(8'h70, 8'hff);
    rd(8'h70, 8'h00);
    rd(8'h62, 8'h00);
    @(posedge clk);
    #1;
    `CHK(regRdData, 8'h00)
    `CHK(hit, 3'b000)
  endtask

  // Select one decode, ignored low bits and disable bit
  task automatic t_sel_one();
    wr(8'h62, 8'h03);
    wr(8'h63, 8'h44);
    rd(8'h63, 8'h44);
    // Nonzero data must be gone one cycle after it stood
    @(posedge clk);
    #1;
    `CHK(regRdData, 8'h00)
    io(16'h0344, 3'b001);
    io(16'h0347, 3'b001);
    io(16'h0348, 3'b000);
    wr(8'h63, 8'h45);
    io(16'h0344, 3'b000);
  endtask

  // Select two in both layouts; bits 3:2 hidden and not compared in mode two
  task automatic t_sel_two();
    wr(8'h64, 8'h02);
    wr(8'h65, 8'h5c);
    rd(8'h64, 8'h02);
    rd(8'h65, 8'h5c);
    io(16'h025c, 3'b010);
    io(16'h0258, 3'b000);
    @(posedge clk);
    busModeTwo <= 1'b1;
    rd(8'h65, 8'h50);
    rd(8'h63, 8'h45);
    io(16'h0258, 3'b010);
    wr(8'h65, 8'h51);
    io(16'h025c, 3'b000);
    @(posedge clk);
    busModeTwo <= 1'b0;
  endtask

  // Select three decode
  task automatic t_sel_three();
    wr(8'h66, 8'h0a);
    wr(8'h67, 8'h30);
    rd(8'h66, 8'h0a);
    io(16'h0a31, 3'b100);
    wr(8'h67, 8'h31);
    io(16'h0a31, 3'b000);
  endtask

  // Protect on every pair; survives zero writes and soft reset, not reset
  task automatic t_protect();
    for (int s = 0; s < 3; s++) begin
      wr(8'(8'h62 + 2 * s), 8'h01);
      wr(8'(8'h63 + 2 * s), 8'h06);
      wr(8'(8'h62 + 2 * s), 8'h0f);
      rd(8'(8'h62 + 2 * s), 8'h01);
      wr(8'(8'h63 + 2 * s), 8'h00);
      rd(8'(8'h63 + 2 * s), 8'h06);
    end
    @(posedge clk);
    softRst <= 1'b1;
    @(posedge clk);
    softRst <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      rd(8'(8'h63 + 2 * s), 8'h02);
      rd(8'(8'h62 + 2 * s), 8'h00);
    end
    doReset();
    for (int s = 0; s < 3; s++) begin
      rd(8'(8'h63 + 2 * s), 8'h00);
    end
  endtask

  // A base above the permitted range never selects
  task automatic t_range();
    wr(8'h62, 8'h10);
    wr(8'h66, 8'h10);
    wr(8'h63, 8'h00);
    io(16'h1000, 3'b000);
  endtask

  // -----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // -----------------------------------------------------------------
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    errCount = 0;
    checkCount = 0;
    rstn = 1'b0;
    softRst = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    busModeTwo = 1'b0;
    ioValid = 1'b0;
    ioAddr = 16'h0000;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset_vals();
    t_sel_one();
    t_sel_two();
    t_sel_three();
    t_protect();
    t_range();
    reportAndStop();
  end

  // Whole run needs about 150 cycles; cut off far beyond that
  initial begin
    #400us;
    errCount++;
    reportAndStop();
  end
endmodule
`default_nettype wire
